// >>> rtl/pdd_consts.svh
`ifndef PDD_CONSTS_SVH
`define PDD_CONSTS_SVH
// Timer and sample widths
`define PDD_TW 16
`define PDD_SW 16
// Full-scale duty value and queue depth
`define PDD_SCALE 16'h0100
`define PDD_DEPTH 4
`define PDD_DEPTH_LOG2 2
`define PDD_PTR_W 2
`define PDD_CNT_W 3
// Reset values
`define PDD_TS_RST 16'h0000
`define PDD_ZERO_SAMPLE 16'h0000
// Analog (1) or digital (0) handling, fixed at build time
`define PDD_ANALOG 1'b0
// Non-inverted (0) or inverted (1) input polarity
`define PDD_INVERT 1'b0
`endif

// >>> rtl/pdd_pkg.sv
`include "pdd_consts.svh"
package pdd_pkg;
    typedef logic [`PDD_TW-1:0] pdd_ts_t;
    typedef logic [`PDD_SW-1:0] pdd_smp_t;
    typedef struct packed {
        logic valid;
        pdd_smp_t duty;
    } pdd_sample_s;
    typedef enum logic [1:0] {
        PDD_IDLE,
        PDD_DIVIDE,
        PDD_PUSH
    } pdd_state_e;
endpackage : pdd_pkg

// >>> rtl/pdd_queue_mem.sv
`timescale 1ns/100ps
`include "pdd_consts.svh"
module pdd_queue_mem (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic wr_en_in,
    input wire logic [`PDD_PTR_W-1:0] wr_addr_in,
    input wire pdd_pkg::pdd_smp_t wr_data_in,
    input wire logic [`PDD_PTR_W-1:0] rd_addr_in,
    output pdd_pkg::pdd_smp_t rd_data_out
);
    import pdd_pkg::*;
    pdd_smp_t mem_q [`PDD_DEPTH];

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < `PDD_DEPTH; i++) begin
                mem_q[i] <= `PDD_ZERO_SAMPLE;
            end
        end else if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_data_out <= `PDD_ZERO_SAMPLE;
        end else begin
            rd_data_out <= mem_q[rd_addr_in];
        end
    end
endmodule : pdd_queue_mem

// >>> rtl/pdd_demod.sv
`timescale 1ns/100ps
`include "pdd_consts.svh"
module pdd_demod (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic capture_input_pin_in,
    input wire logic rd_req_in,
    output logic rd_ready_out,
    output pdd_pkg::pdd_sample_s rd_out,
    output pdd_pkg::pdd_ts_t capture_timestamp_out,
    output logic capture_evt_out,
    output logic edge_lead_out,
    output logic fifo_empty_out,
    output logic fifo_full_out
);
    import pdd_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic pdd_ts_t ts_diff(input pdd_ts_t a, input pdd_ts_t b);
        ts_diff = a - b;
    endfunction : ts_diff

    function automatic logic [`PDD_PTR_W-1:0] ptr_inc(input logic [`PDD_PTR_W-1:0] p);
        ptr_inc = p + 1'b1;
    endfunction : ptr_inc

    // ------------------------------------------------------------
    // Pin synchroniser and free-running timer
    // ------------------------------------------------------------
    logic pin_s1_q;
    logic pin_s2_q;
    logic pin_s3_q;
    pdd_ts_t timer_q;

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_s1_q <= `PDD_INVERT;
            pin_s2_q <= `PDD_INVERT;
            pin_s3_q <= `PDD_INVERT;
        end else begin
            pin_s1_q <= capture_input_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            timer_q <= `PDD_TS_RST;
        end else begin
            timer_q <= timer_q + 1'b1;
        end
    end

    // Active level of the pin after polarity correction
    logic act_now;
    logic act_prev;
    assign act_now = pin_s2_q ^ `PDD_INVERT;
    assign act_prev = pin_s3_q ^ `PDD_INVERT;

    // ------------------------------------------------------------
    // Edge sense and capture
    // ------------------------------------------------------------
    // Edges are ignored while the divider runs; a trailing edge lost that
    // way is taken as a zero-width pulse so the edge sense stays in step.
    logic sense_lead_q;
    logic lead_hit;
    logic trail_hit;
    logic lost_trail;
    logic busy;
    logic timeout_hit;
    pdd_ts_t start_q;
    assign lead_hit = sense_lead_q && act_now && !act_prev && !busy;
    assign trail_hit = !sense_lead_q && !act_now && act_prev && !busy;
    assign lost_trail = !sense_lead_q && !act_now && !act_prev && !busy;

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sense_lead_q <= 1'b1;
        end else if (lead_hit || trail_hit || lost_trail) begin
            sense_lead_q <= !sense_lead_q;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            capture_timestamp_out <= `PDD_TS_RST;
            capture_evt_out <= 1'b0;
            edge_lead_out <= 1'b0;
        end else begin
            capture_evt_out <= lead_hit || trail_hit || lost_trail;
            if (lead_hit || trail_hit) begin
                capture_timestamp_out <= timer_q;
                edge_lead_out <= lead_hit;
            end else if (lost_trail) begin
                capture_timestamp_out <= start_q;
                edge_lead_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Period, width and timeout
    // ------------------------------------------------------------
    pdd_ts_t stop_q;
    pdd_ts_t period_q;
    pdd_ts_t width_q;
    pdd_ts_t last_period_q;
    pdd_ts_t deadline_q;
    logic started_q;
    logic tmo_arm_q;
    logic force_q;
    logic force_val_q;
    // A leading edge landing right on the deadline wins: the period was as expected
    assign timeout_hit = tmo_arm_q && (timer_q == deadline_q) && !busy && !lead_hit;

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            start_q <= `PDD_TS_RST;
            stop_q <= `PDD_TS_RST;
            period_q <= `PDD_TS_RST;
            width_q <= `PDD_TS_RST;
            started_q <= 1'b0;
        end else if (lead_hit) begin
            period_q <= ts_diff(timer_q, start_q);
            width_q <= ts_diff(stop_q, start_q);
            start_q <= timer_q;
            started_q <= 1'b1;
        end else if (trail_hit) begin
            stop_q <= timer_q;
        end else if (lost_trail) begin
            stop_q <= start_q;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            last_period_q <= `PDD_TS_RST;
            deadline_q <= `PDD_TS_RST;
            tmo_arm_q <= 1'b0;
        end else if (lead_hit) begin
            if (started_q) begin
                last_period_q <= ts_diff(timer_q, start_q);
                deadline_q <= timer_q + ts_diff(timer_q, start_q);
                tmo_arm_q <= 1'b1;
            end
        end else if (timeout_hit) begin
            deadline_q <= deadline_q + last_period_q;
        end
    end

    // Flat line with no edge by the deadline: force 0% or 100%
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            force_q <= 1'b0;
            force_val_q <= 1'b0;
        end else begin
            force_q <= 1'b0;
            if (timeout_hit) begin
                force_q <= 1'b1;
                force_val_q <= act_now;
            end
        end
    end

    // ------------------------------------------------------------
    // Serial divider: duty = scale * width / period
    // ------------------------------------------------------------
    pdd_state_e state_q;
    logic [`PDD_TW+`PDD_SW-1:0] num_q;
    logic [`PDD_TW:0] rem_q;
    logic [5:0] bit_q;
    pdd_smp_t result_q;
    logic push_q;
    logic [`PDD_TW:0] rem_sh;
    assign busy = (state_q != PDD_IDLE);
    assign rem_sh = {rem_q[`PDD_TW-1:0], num_q[`PDD_TW+`PDD_SW-1]};

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= PDD_IDLE;
            num_q <= '0;
            rem_q <= '0;
            bit_q <= '0;
            result_q <= `PDD_ZERO_SAMPLE;
            push_q <= 1'b0;
        end else begin
            push_q <= 1'b0;
            unique case (state_q)
                PDD_IDLE: begin
                    if (force_q) begin
                        result_q <= force_val_q ? `PDD_SCALE : `PDD_ZERO_SAMPLE;
                        push_q <= 1'b1;
                    end else if (lead_hit && started_q) begin
                        num_q <= `PDD_TW'(ts_diff(stop_q, start_q)) * `PDD_SCALE;
                        rem_q <= '0;
                        bit_q <= 6'(`PDD_TW + `PDD_SW);
                        state_q <= PDD_DIVIDE;
                    end
                end
                PDD_DIVIDE: begin
                    num_q <= {num_q[`PDD_TW+`PDD_SW-2:0], 1'b0};
                    if ((period_q != '0) && (rem_sh >= {1'b0, period_q})) begin
                        rem_q <= rem_sh - {1'b0, period_q};
                        result_q <= {result_q[`PDD_SW-2:0], 1'b1};
                    end else begin
                        rem_q <= rem_sh;
                        result_q <= {result_q[`PDD_SW-2:0], 1'b0};
                    end
                    bit_q <= bit_q - 1'b1;
                    if (bit_q == 6'h01) begin
                        state_q <= PDD_PUSH;
                    end
                end
                PDD_PUSH: begin
                    push_q <= 1'b1;
                    state_q <= PDD_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sample queue
    // ------------------------------------------------------------
    logic [`PDD_PTR_W-1:0] wr_ptr_q;
    logic [`PDD_PTR_W-1:0] rd_ptr_q;
    logic [`PDD_CNT_W-1:0] count_q;
    logic [`PDD_SW+`PDD_DEPTH_LOG2-1:0] sum_q;
    pdd_smp_t mem_rd;
    pdd_smp_t old_entry;
    logic wr_ok;
    logic rd_take;
    logic q_full;
    logic q_empty;
    assign q_full = (count_q == `PDD_CNT_W'(`PDD_DEPTH));
    assign q_empty = (count_q == '0);
    assign wr_ok = push_q && (`PDD_ANALOG || !q_full);
    assign rd_take = rd_req_in && rd_ready_out && !`PDD_ANALOG && !q_empty;

    logic [`PDD_CNT_W-1:0] count_d;
    always_comb begin
        count_d = count_q;
        if (`PDD_ANALOG) begin
            if (wr_ok && !q_full) begin
                count_d = count_q + 1'b1;
            end
        end else if (wr_ok && !rd_take) begin
            count_d = count_q + 1'b1;
        end else if (rd_take && !wr_ok) begin
            count_d = count_q - 1'b1;
        end
    end

    pdd_queue_mem u_mem (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .wr_en_in(wr_ok),
        .wr_addr_in(wr_ptr_q),
        .wr_data_in(result_q),
        .rd_addr_in(`PDD_ANALOG ? wr_ptr_q : rd_ptr_q),
        .rd_data_out(mem_rd)
    );

    // In analog mode the read port looks at the slot about to be overwritten
    assign old_entry = mem_rd;

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (wr_ok) begin
                wr_ptr_q <= ptr_inc(wr_ptr_q);
            end
            if (rd_take) begin
                rd_ptr_q <= ptr_inc(rd_ptr_q);
            end
            count_q <= count_d;
        end
    end

    // Running sum over all N slots; unfilled slots count as zero
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sum_q <= '0;
        end else if (wr_ok && `PDD_ANALOG) begin
            sum_q <= sum_q + result_q - old_entry;
        end
    end

    // ------------------------------------------------------------
    // Read port: request/answer in two cycles, or one for an empty queue or analog mode; one request in flight
    // ------------------------------------------------------------
    // The RAM read register adds a cycle; wr_ok is blocked from
    // changing the answer by sampling the value in the take cycle.
    logic rd_pend_q;
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_pend_q <= 1'b0;
            rd_ready_out <= 1'b1;
            rd_out <= '0;
            fifo_empty_out <= 1'b1;
            fifo_full_out <= 1'b0;
        end else begin
            // Flags follow the count stored at this edge, so a request in
            // the cycle after a push sees the true occupancy
            fifo_empty_out <= (count_d == '0);
            fifo_full_out <= (count_d == `PDD_CNT_W'(`PDD_DEPTH));
            rd_out.valid <= 1'b0;
            rd_pend_q <= 1'b0;
            if (rd_req_in && rd_ready_out) begin
                rd_ready_out <= 1'b0;
                if (`PDD_ANALOG) begin
                    rd_out.valid <= 1'b1;
                    rd_out.duty <= `PDD_SW'(sum_q >> `PDD_DEPTH_LOG2);
                    rd_ready_out <= 1'b1;
                end else if (q_empty) begin
                    rd_out.valid <= 1'b1;
                    rd_out.duty <= `PDD_SCALE;
                    rd_ready_out <= 1'b1;
                end else begin
                    rd_pend_q <= 1'b1;
                end
            end
            if (rd_pend_q) begin
                rd_out.valid <= 1'b1;
                rd_out.duty <= mem_rd;
                rd_ready_out <= 1'b1;
            end
        end
    end
endmodule : pdd_demod

// >>> tb/pdd_pwm_src.sv
`timescale 1ns/100ps
// ----------------------------------------
// Pulse source standing in for the sensor
// ----------------------------------------
module pdd_pwm_src (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic en_in,
    input wire logic [15:0] period_in,
    input wire logic [15:0] width_in,
    output logic pin_out
);
    logic [15:0] cnt_q;
    logic [15:0] wid_q;

    // Width is taken at the period boundary so a change never cuts a pulse short
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q <= 16'h0000;
            wid_q <= 16'h0000;
            pin_out <= 1'b0;
        end else if (en_in) begin
            cnt_q <= (cnt_q == period_in - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
            if (cnt_q == period_in - 16'h0001) begin
                wid_q <= width_in;
            end
            pin_out <= (cnt_q < wid_q);
        end
    end
endmodule : pdd_pwm_src

// >>> tb/pdd_demod_monitor.sv
`timescale 1ns/100ps
`include "pdd_consts.svh"
module pdd_demod_monitor (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic capture_input_pin_in,
    input wire logic rd_req_in,
    input wire logic rd_ready_out,
    input wire pdd_pkg::pdd_sample_s rd_out,
    input wire pdd_pkg::pdd_ts_t capture_timestamp_out,
    input wire logic capture_evt_out,
    input wire logic edge_lead_out,
    input wire logic fifo_empty_out,
    input wire logic fifo_full_out
);
    import pdd_pkg::*;
    logic seen_q;
    logic lead_q;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);

    // ----------------------------------------
    // Edge history
    // ----------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            seen_q <= 1'b0;
            lead_q <= 1'b0;
        end else if (capture_evt_out) begin
            seen_q <= 1'b1;
            lead_q <= edge_lead_out;
        end
    end

    a_arm_leading: assert property (capture_evt_out && !seen_q |-> edge_lead_out)
        else $error("first capture was not a leading edge");
    a_sense_toggle: assert property (capture_evt_out && seen_q |-> edge_lead_out != lead_q)
        else $error("edge sense did not alternate");
    a_evt_pulse: assert property (capture_evt_out |=> !capture_evt_out)
        else $error("capture event longer than one cycle");
    a_evt_level: assert property (
        capture_evt_out |-> $past(capture_input_pin_in, 2) == edge_lead_out)
        else $error("capture edge disagrees with pin level");
    a_ts_stable: assert property (!capture_evt_out |-> $stable(capture_timestamp_out))
        else $error("timestamp moved without a capture");
    a_read_answer: assert property (rd_req_in && rd_ready_out |-> ##[1:2] rd_out.valid)
        else $error("read not answered in time");
    a_valid_cause: assert property (
        rd_out.valid |-> $past(rd_req_in) || $past(rd_req_in, 2))
        else $error("sample returned without a request");
    a_empty_idle: assert property (rd_req_in && rd_ready_out && fifo_empty_out
        |=> rd_out.valid && rd_out.duty == `PDD_SCALE)
        else $error("empty read did not return full scale");
    a_duty_range: assert property (rd_out.valid |-> rd_out.duty <= `PDD_SCALE)
        else $error("duty above full scale");
    a_occupancy_sane: assert property (!(fifo_empty_out && fifo_full_out))
        else $error("queue empty and full together");

    cover property (capture_evt_out && edge_lead_out);
    cover property (rd_out.valid && rd_out.duty != `PDD_SCALE);
    cover property (fifo_full_out && rd_req_in);
endmodule : pdd_demod_monitor

bind pdd_demod pdd_demod_monitor pdd_demod_monitor_inst (.clk_sys_in, .rst_b_in,
    .capture_input_pin_in, .rd_req_in, .rd_ready_out, .rd_out, .capture_timestamp_out,
    .capture_evt_out, .edge_lead_out, .fifo_empty_out, .fifo_full_out);

// >>> tb/pdd_demod_tb_top.sv
`timescale 1ns/100ps
`include "pdd_consts.svh"
module pdd_demod_tb_top;
    import pdd_pkg::*;
    localparam int PER = 200;
    logic clk_sys_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic rd_req = 1'b0;
    logic en = 1'b0;
    logic [15:0] wid = 16'h0032;
    logic pin, rdy, evt, lead, emp, full;
    pdd_sample_s rd;
    pdd_ts_t ts, lead_ts;
    logic [15:0] cur_w;
    logic [15:0] w_exp;
    pdd_smp_t d;
    int miscompares = 0;
    int checks_done = 0;
    int leads = 0;

    initial begin
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    pdd_demod pdd_demod_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .capture_input_pin_in(pin), .rd_req_in(rd_req), .rd_ready_out(rdy), .rd_out(rd),
        .capture_timestamp_out(ts), .capture_evt_out(evt), .edge_lead_out(lead),
        .fifo_empty_out(emp), .fifo_full_out(full));
    pdd_pwm_src pdd_pwm_src_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .en_in(en), .period_in(16'h00C8), .width_in(wid), .pin_out(pin));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    function automatic pdd_smp_t duty(input logic [15:0] w);
        return 16'((`PDD_SCALE * w) / PER);
    endfunction : duty

    task automatic rd_smp(output pdd_smp_t v);
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 20) begin
            @(negedge clk_sys_in);
            n++;
        end
        rd_req = 1'b1;
        @(negedge clk_sys_in);
        rd_req = 1'b0;
        n = 0;
        while (rd.valid !== 1'b1 && n < 5) begin
            @(negedge clk_sys_in);
            n++;
        end
        if (n == 5) miscompares++;
        v = rd.duty;
        // Let an edge pass so a following call never re-raises the request at once
        @(negedge clk_sys_in);
    endtask : rd_smp

    task automatic wait_leads(input int n);
        int t;
        int c;
        t = leads + n;
        c = 0;
        while (leads < t && c < 2000) begin
            @(negedge clk_sys_in);
            c++;
        end
        if (c == 2000) miscompares++;
    endtask : wait_leads

    // Period and width seen through the timestamps; 16-bit subtraction wraps
    always @(negedge clk_sys_in) begin
        if (evt === 1'b1 && lead === 1'b1) begin
            if (leads > 0) chk("period", 16'(PER), 16'(ts - lead_ts));
            lead_ts = ts;
            cur_w = wid;
            leads++;
        end else if (evt === 1'b1) begin
            chk("width", cur_w, 16'(ts - lead_ts));
        end
    end

    initial begin
        repeat (5000) @(posedge clk_sys_in);
        miscompares++;
        end_sim;
    end

    initial begin
        repeat (4) @(negedge clk_sys_in);
        rst_b_in = 1'b1;
        chk("ready", 16'h0001, 16'(rdy));
        chk("empty", 16'h0001, 16'(emp));
        chk("full", 16'h0000, 16'(full));
        rd_smp(d);
        chk("idle duty", `PDD_SCALE, d);
        $display("test reset and empty read done");
        en = 1'b1;
        wait_leads(3);
        wid = 16'h0064;
        wait_leads(3);
        repeat (40) @(negedge clk_sys_in);
        chk("full", 16'h0001, 16'(full));
        // Fifth sample arrived while full and must be gone
        for (int i = 0; i < 4; i++) begin
            w_exp = (i < 3) ? 16'h0032 : 16'h0064;
            rd_smp(d);
            chk("duty", duty(w_exp), d);
            chk("inverted duty", duty(16'(PER) - w_exp), 16'(`PDD_SCALE - d));
        end
        rd_smp(d);
        chk("idle duty", `PDD_SCALE, d);
        repeat (2) @(negedge clk_sys_in);
        chk("empty", 16'h0001, 16'(emp));
        $display("test capture, queue and drain done");
        // No leading edge from here on, so only the period timeout can store a sample
        wid = 16'h0000;
        repeat (300) @(negedge clk_sys_in);
        chk("timeout queued", 16'h0000, 16'(emp));
        rd_smp(d);
        chk("flat low duty", 16'h0000, d);
        $display("test flat line timeout done");
        end_sim;
    end
endmodule : pdd_demod_tb_top
